/* File: include/ssrp_defs.svh */
/*
  Offsets, field positions, reset values and timing counts of the stop
  sequencer and ramp profile block. Assumes a 10 MHz control clock.
*/
`ifndef SSRP_DEFS_SVH
`define SSRP_DEFS_SVH

// timing: clock period, control tick time, derived tick cycle count
`define SSRP_CLK_PERIOD_NS 32'h64
`define SSRP_TICK_TIME_US  32'h3E8
`define SSRP_NS_PER_US     32'h3E8
`define SSRP_TICK_CYCLES   ((`SSRP_TICK_TIME_US * `SSRP_NS_PER_US) / `SSRP_CLK_PERIOD_NS)
`define SSRP_U_SHIFT       4
`define SSRP_MIN_STEP      32'h0000_0100
`define SSRP_PCT_FULL      40'h00_0000_0064

// register byte addresses
`define SSRP_A_CMD     8'h00
`define SSRP_A_CFG     8'h04
`define SSRP_A_TARGET  8'h08
`define SSRP_A_FMAX    8'h0C
`define SSRP_A_ACC_T   8'h10
`define SSRP_A_DEC_T   8'h14
`define SSRP_A_SLOPE   8'h18
`define SSRP_A_BRK_F   8'h1C
`define SSRP_A_PREBLK  8'h20
`define SSRP_A_BRK_T   8'h24
`define SSRP_A_BRK_AMT 8'h28
`define SSRP_A_RATED   8'h2C
`define SSRP_A_FOUT    8'h30
`define SSRP_A_STATUS  8'h34

// field positions
`define SSRP_CMD_RUN   0
`define SSRP_CMD_STOP  1
`define SSRP_CFG_METH  0
`define SSRP_CFG_ACC   2
`define SSRP_CFG_DEC   4
`define SSRP_CFG_REF   6
`define SSRP_SLOPE_END 8

// reset values
`define SSRP_TARGET_RST  16'h1770
`define SSRP_FMAX_RST    16'h1770
`define SSRP_ACC_T_RST   16'h2710
`define SSRP_DEC_T_RST   16'h2710
`define SSRP_BRK_F_RST   16'h01F4
`define SSRP_PREBLK_RST  16'h0064
`define SSRP_BRK_T_RST   16'h03E8
`define SSRP_BRK_AMT_RST 8'h32
`define SSRP_RATED_RST   16'h0064

`endif

/* File: include/ssrp_pkg.sv */
/*
  Types of the stop sequencer and ramp profile block.
  Assumes ssrp_defs.svh for all numeric constants but the enum codes.
*/
package ssrp_pkg;
  // sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_STOP   = 5'h01,
    ST_CALC   = 5'h02,
    ST_RUN    = 5'h04,
    ST_PREBLK = 5'h08,
    ST_BRAKE  = 5'h10
  } ssrp_st_type;
  // stop methods; code 3 acts as a ramped stop
  typedef enum logic [1:0] {
    SM_COAST = 2'h0,
    SM_RAMP  = 2'h1,
    SM_DCBRK = 2'h2
  } ssrp_stop_type;
  // ramp shapes; code 3 acts as linear
  typedef enum logic [1:0] {
    SH_LINEAR = 2'h0,
    SH_SCURVE = 2'h1,
    SH_UCURVE = 2'h2
  } ssrp_shape_type;
endpackage

/* File: hw/ssrp_div.sv */
/*
  Serial restoring divider, one quotient bit per clock.
  Assumes the caller holds operands stable only in the start cycle and
  never divides by zero.
*/
`timescale 1ns/1ps
module ssrp_div #(
  parameter int W = 40
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // request
  input  wire logic         start,
  input  wire logic [W-1:0] num,
  input  wire logic [W-1:0] den,
  // answer
  output logic              busy,
  output logic [W-1:0]      quo
);
  localparam int CW = $clog2(W + 1);
  typedef struct packed {
    logic          busy;
    logic [W-1:0]  q;
    logic [W:0]    r;
    logic [W-1:0]  d;
    logic [CW-1:0] cnt;
  } ssrp_div_type;

  if (W < 2) begin : g_chk
    $error("ssrp_div: W must be at least 2");
  end

  ssrp_div_type s_r;
  ssrp_div_type s_nxt;
  logic [W:0]   rsh;

  // one shift-subtract step per cycle; start restarts even when busy
  always_comb begin
    s_nxt = s_r;
    rsh   = {s_r.r[W-1:0], s_r.q[W-1]};
    if (start) begin
      s_nxt.busy = 1'b1;
      s_nxt.q    = num;
      s_nxt.r    = '0;
      s_nxt.d    = den;
      s_nxt.cnt  = CW'(W);
    end else if (s_r.busy) begin
      if (rsh >= {1'b0, s_r.d}) begin
        s_nxt.r = rsh - {1'b0, s_r.d};
        s_nxt.q = {s_r.q[W-2:0], 1'b1};
      end else begin
        s_nxt.r = rsh;
        s_nxt.q = {s_r.q[W-2:0], 1'b0};
      end
      s_nxt.cnt  = s_r.cnt - CW'(1);
      s_nxt.busy = (s_r.cnt != CW'(1));
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign busy = s_r.busy;
  assign quo  = s_r.q;
endmodule

/* File: hw/ssrp_top.sv */
/*
  Stop sequencer and accel/decel profile generator for a drive frequency
  command. Assumes a plain register port, a 10 MHz clock, and a power stage
  that follows gate_en, out_freq, dc_brake_en and dc_current_ref.
*/
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "ssrp_defs.svh"
module ssrp_top #(
  parameter int TICK_CYCLES = `SSRP_TICK_CYCLES,
  parameter int U_SHIFT     = `SSRP_U_SHIFT
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic [31:0]      rdata,
  // power stage
  output logic             gate_en,
  output logic [15:0]      out_freq,
  output logic             dc_brake_en,
  output logic [15:0]      dc_current_ref,
  output logic             stopped
);
  import ssrp_pkg::*;

  if (TICK_CYCLES < 1 || TICK_CYCLES > 24'hFFFFFF || U_SHIFT < 1 || U_SHIFT > 15) begin : g_chk
    $error("ssrp_top: parameter out of range");
  end

  typedef struct packed {
    ssrp_st_type  st;
    logic [1:0]   method;
    logic [1:0]   acc_sh;
    logic [1:0]   dec_sh;
    logic         ref_delta;
    logic [15:0]  target;
    logic [15:0]  fmax;
    logic [15:0]  acc_t;
    logic [15:0]  dec_t;
    logic [7:0]   s_start;
    logic [7:0]   s_end;
    logic [15:0]  brk_f;
    logic [15:0]  preblk_t;
    logic [15:0]  brk_t;
    logic [7:0]   brk_amt;
    logic [15:0]  rated;
    logic         stop_req;
    logic         stopping;
    logic         accel;
    logic [1:0]   shape;
    logic [15:0]  goal;
    logic [31:0]  freq;
    logic [31:0]  step;
    logic [31:0]  cur;
    logic [31:0]  jup;
    logic [31:0]  jdn;
    logic [31:0]  rise;
    logic [31:0]  fall;
    logic [31:0]  total;
    logic [31:0]  tcnt;
    logic [23:0]  tcyc;
    logic [15:0]  tmr;
    logic [2:0]   didx;
    logic         dstart;
    logic [15:0]  dc_ref;
    logic         gate;
    logic         dc_en;
    logic         stp;
    logic [15:0]  fout;
    logic [31:0]  rdata;
  } ssrp_reg_type;

  localparam logic [23:0] TICK_LOAD = 24'(TICK_CYCLES - 1);
  localparam ssrp_reg_type RST_VAL = '{
    st: ST_STOP, method: SM_RAMP, acc_sh: SH_LINEAR, dec_sh: SH_LINEAR,
    target: `SSRP_TARGET_RST, fmax: `SSRP_FMAX_RST, acc_t: `SSRP_ACC_T_RST,
    dec_t: `SSRP_DEC_T_RST, brk_f: `SSRP_BRK_F_RST, preblk_t: `SSRP_PREBLK_RST,
    brk_t: `SSRP_BRK_T_RST, brk_amt: `SSRP_BRK_AMT_RST, rated: `SSRP_RATED_RST,
    stp: 1'b1, default: '0};

  ssrp_reg_type s_r;
  ssrp_reg_type n;
  logic         div_busy;
  logic [39:0]  div_q;
  logic [39:0]  dnum;
  logic [39:0]  dden;
  logic         tick;
  logic         calc;
  logic         run_wr;
  logic         stop_wr;
  logic         stop_cmd;
  logic [15:0]  fint;
  logic [15:0]  tsel;
  logic [15:0]  fref;
  logic [31:0]  goal_q;
  logic [31:0]  diff;
  logic [31:0]  stepe;
  logic [31:0]  c;

  // zero guard, used for divisors and counts
  function automatic logic [31:0] nz32(input logic [31:0] x);
    return (x == 32'h0) ? 32'h1 : x;
  endfunction

  // read mux; unmapped offsets read zero
  function automatic logic [31:0] reg_read(input logic [7:0] a);
    case (a)
      `SSRP_A_CFG:     return {25'h0, s_r.ref_delta, s_r.dec_sh, s_r.acc_sh, s_r.method};
      `SSRP_A_TARGET:  return {16'h0, s_r.target};
      `SSRP_A_FMAX:    return {16'h0, s_r.fmax};
      `SSRP_A_ACC_T:   return {16'h0, s_r.acc_t};
      `SSRP_A_DEC_T:   return {16'h0, s_r.dec_t};
      `SSRP_A_SLOPE:   return {16'h0, s_r.s_end, s_r.s_start};
      `SSRP_A_BRK_F:   return {16'h0, s_r.brk_f};
      `SSRP_A_PREBLK:  return {16'h0, s_r.preblk_t};
      `SSRP_A_BRK_T:   return {16'h0, s_r.brk_t};
      `SSRP_A_BRK_AMT: return {24'h0, s_r.brk_amt};
      `SSRP_A_RATED:   return {16'h0, s_r.rated};
      `SSRP_A_FOUT:    return {16'h0, s_r.fout};
      `SSRP_A_STATUS:  return {22'h0, s_r.stopping, s_r.stop_req, s_r.dc_en, s_r.gate, 1'b0, s_r.st};
      default:         return 32'h0;
    endcase
  endfunction

  ssrp_div #(.W(40)) u_div (
    .clk   (clk),
    .rst_n (rst_n),
    .start (s_r.dstart),
    .num   (dnum),
    .den   (dden),
    .busy  (div_busy),
    .quo   (div_q)
  );

  // shared ramp terms
  assign fint   = s_r.freq[31:16];
  assign tsel   = s_r.accel ? s_r.acc_t : s_r.dec_t;
  assign goal_q = {s_r.goal, 16'h0};
  assign diff   = s_r.accel ? goal_q - s_r.freq : s_r.freq - goal_q;
  assign stepe  = (s_r.step < `SSRP_MIN_STEP) ? `SSRP_MIN_STEP : s_r.step;
  assign fref   = s_r.ref_delta ? diff[31:16] : s_r.fmax;
  assign run_wr  = wr_en && (addr == `SSRP_A_CMD) && wdata[`SSRP_CMD_RUN];
  assign stop_wr = wr_en && (addr == `SSRP_A_CMD) && wdata[`SSRP_CMD_STOP];
  assign stop_cmd = s_r.stop_req | stop_wr;

  // divider operands, one division per setup slot
  always_comb begin
    dnum = 40'h0;
    dden = 40'h1;
    case (s_r.didx)
      3'h0: begin
        dnum = {8'h0, fref, 16'h0};
        dden = {8'h0, nz32({16'h0, tsel})};
      end
      3'h1: begin
        dnum = {16'h0, 24'(tsel) * 24'(s_r.s_start)};
        dden = `SSRP_PCT_FULL;
      end
      3'h2: begin
        dnum = {16'h0, 24'(tsel) * 24'(s_r.s_end)};
        dden = `SSRP_PCT_FULL;
      end
      3'h3: begin
        dnum = {8'h0, s_r.step};
        dden = {8'h0, nz32(s_r.rise)};
      end
      3'h4: begin
        dnum = {8'h0, s_r.step};
        dden = {8'h0, nz32(s_r.fall)};
      end
      3'h5: begin
        dnum = {16'h0, 24'(s_r.rated) * 24'(s_r.brk_amt)};
        dden = `SSRP_PCT_FULL;
      end
      default: ;
    endcase
  end

  // sequencer, ramp engine and register writes
  always_comb begin
    n        = s_r;
    calc     = 1'b0;
    c        = s_r.cur;
    tick     = (s_r.tcyc == 24'h0);
    n.tcyc   = tick ? TICK_LOAD : s_r.tcyc - 24'h1;
    n.dstart = 1'b0;
    n.rdata  = rd_en ? reg_read(addr) : 32'h0;
    n.stop_req = stop_cmd;
    unique case (s_r.st)
      ST_STOP: begin
        n.stop_req = 1'b0;
        if (run_wr) begin
          n.goal     = s_r.target;
          n.freq     = 32'h0;
          n.stopping = 1'b0;
          calc       = 1'b1;
        end
      end
      ST_CALC, ST_RUN: begin
        if (stop_cmd && !s_r.stopping) begin
          n.stop_req = 1'b0;
          if (s_r.method == SM_COAST) begin
            n.st   = ST_STOP;
            n.freq = 32'h0;
          end else begin
            n.stopping = 1'b1;
            if (s_r.method == SM_DCBRK) begin
              n.goal = (s_r.brk_f < fint) ? s_r.brk_f : fint;
            end else begin
              n.goal = 16'h0;
            end
            calc = 1'b1;
          end
        end else if (s_r.stopping) begin
          n.stop_req = 1'b0;
        end
        if (!calc && s_r.st == ST_STOP) begin
          n.st = ST_STOP;
        end else if (!calc && s_r.st == ST_CALC && n.st == ST_CALC) begin
          if (!s_r.dstart && !div_busy) begin
            case (s_r.didx)
              3'h0: n.step = div_q[31:0];
              3'h1: n.rise = div_q[31:0];
              3'h2: n.fall = div_q[31:0];
              3'h3: n.jup  = div_q[31:0];
              3'h4: n.jdn  = div_q[31:0];
              default: n.dc_ref = div_q[15:0];
            endcase
            if (s_r.didx == 3'h5) begin
              n.st = ST_RUN;
              n.total = {16'h0, tsel} + (s_r.rise >> 1) + (s_r.fall >> 1);
            end else begin
              n.didx   = s_r.didx + 3'h1;
              n.dstart = 1'b1;
            end
          end
        end else if (!calc && s_r.st == ST_RUN && n.st == ST_RUN) begin
          if (!s_r.stopping && s_r.target != s_r.goal) begin
            n.goal = s_r.target;
            calc   = 1'b1;
          end else if (tick && diff == 32'h0) begin
            if (s_r.stopping && s_r.method == SM_DCBRK) begin
              n.st  = ST_PREBLK;
              n.tmr = 16'h0;
            end else if (s_r.stopping) begin
              n.st = ST_STOP;
            end
          end else if (tick) begin
            case (s_r.shape)
              SH_SCURVE: begin
                if (s_r.tcnt < s_r.rise) begin
                  c = (s_r.cur + s_r.jup > stepe) ? stepe : s_r.cur + s_r.jup;
                end else if (s_r.tcnt + s_r.fall >= s_r.total) begin
                  c = (s_r.cur > s_r.jdn + `SSRP_MIN_STEP) ? s_r.cur - s_r.jdn : `SSRP_MIN_STEP;
                end else begin
                  c = stepe;
                end
              end
              SH_UCURVE: begin
                c = diff >> U_SHIFT;
                if (c < `SSRP_MIN_STEP) begin
                  c = `SSRP_MIN_STEP;
                end
              end
              default: begin
                c = stepe;
              end
            endcase
            n.cur  = c;
            n.tcnt = s_r.tcnt + 32'h1;
            if (c >= diff) begin
              n.freq = goal_q;
            end else begin
              n.freq = s_r.accel ? s_r.freq + c : s_r.freq - c;
            end
          end
        end
      end
      ST_PREBLK: begin
        n.stop_req = 1'b0;
        n.freq     = 32'h0;
        if (tick) begin
          if (s_r.tmr + 16'h1 >= s_r.preblk_t) begin
            n.st  = ST_BRAKE;
            n.tmr = 16'h0;
          end else begin
            n.tmr = s_r.tmr + 16'h1;
          end
        end
      end
      ST_BRAKE: begin
        n.stop_req = 1'b0;
        if (tick) begin
          if (s_r.tmr + 16'h1 >= s_r.brk_t) begin
            n.st = ST_STOP;
          end else begin
            n.tmr = s_r.tmr + 16'h1;
          end
        end
      end
    endcase
    // setup restart: direction, shape and divisions
    if (calc) begin
      n.st     = ST_CALC;
      n.didx   = 3'h0;
      n.dstart = 1'b1;
      n.tcnt   = 32'h0;
      n.cur    = 32'h0;
      n.accel  = ({n.goal, 16'h0} > n.freq);
      n.shape  = ({n.goal, 16'h0} > n.freq) ? s_r.acc_sh : s_r.dec_sh;
    end
    // register writes; config may change at any time
    if (wr_en) begin
      case (addr)
        `SSRP_A_CFG: begin
          n.method    = wdata[`SSRP_CFG_METH +: 2];
          n.acc_sh    = wdata[`SSRP_CFG_ACC +: 2];
          n.dec_sh    = wdata[`SSRP_CFG_DEC +: 2];
          n.ref_delta = wdata[`SSRP_CFG_REF];
        end
        `SSRP_A_TARGET:  n.target   = wdata[15:0];
        `SSRP_A_FMAX:    n.fmax     = wdata[15:0];
        `SSRP_A_ACC_T:   n.acc_t    = wdata[15:0];
        `SSRP_A_DEC_T:   n.dec_t    = wdata[15:0];
        `SSRP_A_SLOPE: begin
          n.s_start = wdata[7:0];
          n.s_end   = wdata[`SSRP_SLOPE_END +: 8];
        end
        `SSRP_A_BRK_F:   n.brk_f    = wdata[15:0];
        `SSRP_A_PREBLK:  n.preblk_t = wdata[15:0];
        `SSRP_A_BRK_T:   n.brk_t    = wdata[15:0];
        `SSRP_A_BRK_AMT: n.brk_amt  = wdata[7:0];
        `SSRP_A_RATED:   n.rated    = wdata[15:0];
        default: ;
      endcase
    end
    n.gate  = (n.st == ST_CALC) || (n.st == ST_RUN) || (n.st == ST_BRAKE);
    n.dc_en = (n.st == ST_BRAKE);
    n.stp   = (n.st == ST_STOP);
    n.fout  = ((n.st == ST_CALC) || (n.st == ST_RUN)) ? n.freq[31:16] : 16'h0;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r <= RST_VAL;
    end else begin
      s_r <= n;
    end
  end

  assign rdata          = s_r.rdata;
  assign gate_en        = s_r.gate;
  assign out_freq       = s_r.fout;
  assign dc_brake_en    = s_r.dc_en;
  assign dc_current_ref = s_r.dc_ref;
  assign stopped        = s_r.stp;

  // checks on the power-stage outputs and the ramp frequency register
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic [31:0] exp_f;
  always_ff @(posedge clk) begin
    exp_f <= s_r.accel ? s_r.freq + stepe : s_r.freq - stepe;
  end

  coast_block_a: assert property (
    stop_wr && s_r.method == SM_COAST && (s_r.st == ST_RUN || s_r.st == ST_CALC)
    |=> !gate_en && out_freq == 16'h0 && stopped)
    else $error("coast stop left output active");
  stop_idle_a: assert property (
    stopped && !run_wr |=> stopped && !gate_en && !dc_brake_en && out_freq == 16'h0)
    else $error("stopped state not held");
  preblk_hold_a: assert property (
    s_r.st == ST_PREBLK |-> !gate_en && !dc_brake_en && s_r.tmr < nz32({16'h0, s_r.preblk_t}))
    else $error("pre-brake blocking broken");
  brake_end_a: assert property (
    s_r.st == ST_BRAKE && tick && s_r.tmr + 16'h1 >= s_r.brk_t |=> stopped && !dc_brake_en)
    else $error("dc brake did not end on time");
  dc_level_a: assert property (
    $rose(dc_brake_en) |-> dc_current_ref == 16'((24'(s_r.rated) * 24'(s_r.brk_amt)) / 24'h64))
    else $error("dc level wrong");
  ramp_zero_a: assert property (
    s_r.st == ST_RUN && s_r.stopping && s_r.method == SM_RAMP && tick && s_r.freq == 32'h0
    |=> stopped)
    else $error("ramp stop did not finish at zero");
  brake_freq_a: assert property (
    $rose(s_r.st == ST_PREBLK) |-> $past(out_freq) <= s_r.brk_f)
    else $error("brake entered above brake frequency");
  lin_step_a: assert property (
    s_r.st == ST_RUN && s_r.shape == SH_LINEAR && tick && diff > stepe && !stop_cmd
    && s_r.target == s_r.goal && !wr_en |=> s_r.freq == exp_f)
    else $error("linear step wrong");
  u_mono_a: assert property (
    s_r.st == ST_RUN && s_r.accel && s_r.shape == SH_UCURVE && !stop_cmd |=> s_r.freq >= $past(s_r.freq))
    else $error("u-curve went backwards");

  coast_c: cover property (stop_wr && s_r.method == SM_COAST && s_r.st == ST_RUN);
  brake_c: cover property ($fell(dc_brake_en) ##1 stopped);
  scurve_c: cover property (s_r.st == ST_RUN && s_r.shape == SH_SCURVE && tick && s_r.tcnt > s_r.rise);
endmodule

/* File: dv/ssrp_stage_model.sv */
/*
  Behavioural power stage and motor for the stop sequencer bench.
  Assumes the drive outputs change on the rising clock edge.
*/
`timescale 1ns/1ps
module ssrp_stage_model (
  // clock
  input  wire logic        clk,
  // drive outputs
  input  wire logic        gate_en,
  input  wire logic [15:0] out_freq,
  input  wire logic        dc_brake_en,
  // motor state
  output logic [15:0]      motor_freq
);
  initial motor_freq = 16'h0000;
  // live bridge drags the motor, blocked gates let it coast, dc brakes harder
  always @(posedge clk) begin
    if (gate_en && !dc_brake_en)
      motor_freq <= out_freq;
    else if (dc_brake_en)
      motor_freq <= (motor_freq > 16'h0004) ? motor_freq - 16'h0004 : 16'h0000;
    else if (motor_freq != 16'h0000)
      motor_freq <= motor_freq - 16'h0001; // inertia only, slow decay
  end
endmodule

/* File: dv/ssrp_top_bench.sv */
/*
  Self-checking bench of the stop sequencer and ramp profile block.
  Assumes the plain register port and a shortened control tick.
*/
`timescale 1ns/1ps
`include "ssrp_defs.svh"
module ssrp_top_bench;
  localparam int TC = 16;
  logic        clk, rst_n, wr_en, rd_en, bad;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata;
  logic        gate_en, dc_brake_en, stopped;
  logic [15:0] out_freq, dc_current_ref, motor_freq;
  int          miscompares, tests_run, cyc, n, d0, dl;

  ssrp_top #(.TICK_CYCLES(TC), .U_SHIFT(`SSRP_U_SHIFT)) i_ssrp_top (.clk(clk), .rst_n(rst_n),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .gate_en(gate_en),
    .out_freq(out_freq), .dc_brake_en(dc_brake_en), .dc_current_ref(dc_current_ref), .stopped(stopped));
  ssrp_stage_model i_ssrp_stage_model (.clk(clk), .gate_en(gate_en), .out_freq(out_freq),
    .dc_brake_en(dc_brake_en), .motor_freq(motor_freq));

  // 10 MHz clock
  initial clk = 1'b0;
  always #50 clk = ~clk;

  task automatic test_done;
    if (miscompares == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // hang guard, far above the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      test_done();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // tick counts may slip one tick on phase of the free tick
  function automatic int near(input int s, input int e);
    return (s >= e - 1 && s <= e + 1) ? e : s;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 0;
    #1;
    chk("rdata", rdata, e);
  endtask

  // follow out_freq to a goal, counting ticks and first and last step
  task automatic ramp(input logic [15:0] goal);
    logic [15:0] prev;
    int          t, t0;
    prev = out_freq;
    t    = 0;
    t0   = -1;
    d0   = 0;
    while (out_freq !== goal && t < 4000) begin
      @(posedge clk);
      #1;
      t++;
      if (out_freq !== prev) begin
        if (t0 < 0) t0 = t;
        dl = (out_freq > prev) ? out_freq - prev : prev - out_freq;
        if (d0 == 0) d0 = dl;
        prev = out_freq;
      end
    end
    n = (t - t0) / TC + 1;
    chk("goal reached", {16'h0000, out_freq}, {16'h0000, goal});
  endtask

  // run up to goal, stop, ramp to zero, confirm stopped state
  task automatic cycle_run(input logic [31:0] cfg, input logic [15:0] goal, input int up, input int dn);
    wr(`SSRP_A_CFG, cfg);
    wr(`SSRP_A_TARGET, {16'h0000, goal});
    wr(`SSRP_A_CMD, 32'h0000_0001);
    ramp(goal);
    if (up > 0) chk("up ticks", 32'(near(n, up)), 32'(up));
    wr(`SSRP_A_CMD, 32'h0000_0002);
    ramp(16'h0000);
    if (dn > 0) chk("down ticks", 32'(near(n, dn)), 32'(dn));
    n = 0;
    while (stopped !== 1'b1 && n < 100 * TC) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("stopped state", {30'h0, gate_en, stopped}, 32'h1);
  endtask

  // main sequence
  initial begin
    rst_n = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk("idle outputs", {13'h0, gate_en, dc_brake_en, stopped, out_freq}, 32'h0001_0000);
    rd(`SSRP_A_CFG, 32'h1);
    rd(`SSRP_A_STATUS, 32'h1);
    rd(`SSRP_A_TARGET, {16'h0, `SSRP_TARGET_RST});
    rd(`SSRP_A_DEC_T, {16'h0, `SSRP_DEC_T_RST});
    rd(`SSRP_A_BRK_F, {16'h0, `SSRP_BRK_F_RST});
    rd(`SSRP_A_PREBLK, {16'h0, `SSRP_PREBLK_RST});
    rd(`SSRP_A_BRK_T, {16'h0, `SSRP_BRK_T_RST});
    rd(`SSRP_A_BRK_AMT, {24'h0, `SSRP_BRK_AMT_RST});
    rd(8'h3C, 32'h0);
    wr(`SSRP_A_FMAX, 32'h0000_03E8);
    wr(`SSRP_A_ACC_T, 32'h0000_000A);
    wr(`SSRP_A_DEC_T, 32'h0000_000A);
    cycle_run(32'h01, 16'h03E8, 10, 10);
    chk("linear step", 32'(dl), 32'h64);
    cycle_run(32'h41, 16'h01F4, 10, 10);
    cycle_run(32'h01, 16'h01F4, 5, 5);
    wr(`SSRP_A_SLOPE, 32'h0000_2828);
    cycle_run(32'h15, 16'h03E8, 14, 14);
    cycle_run(32'h29, 16'h03E8, 0, 0);
    chk("u-curve slowing", 32'(d0 > dl), 32'h1);
    // coast stop blocks at once while the motor spins on
    wr(`SSRP_A_CFG, 32'h0);
    wr(`SSRP_A_CMD, 32'h1);
    ramp(16'h03E8);
    rd(`SSRP_A_FOUT, 32'h0000_03E8);
    wr(`SSRP_A_CMD, 32'h2);
    #1;
    chk("coast", {14'h0, gate_en, stopped, out_freq}, 32'h0001_0000);
    chk("motor coasting", 32'(motor_freq != 16'h0), 32'h1);
    // dc stop: low brake frequency and half the rated current
    wr(`SSRP_A_BRK_F, 32'h0000_00C8);
    wr(`SSRP_A_PREBLK, 32'h3);
    wr(`SSRP_A_BRK_T, 32'h4);
    wr(`SSRP_A_BRK_AMT, 32'h32);
    wr(`SSRP_A_RATED, 32'h64);
    wr(`SSRP_A_CFG, 32'h2);
    wr(`SSRP_A_CMD, 32'h1);
    ramp(16'h03E8);
    wr(`SSRP_A_CMD, 32'h2);
    ramp(16'h00C8);
    n = 0;
    while (gate_en !== 1'b0 && n < 2 * TC) begin
      @(posedge clk);
      #1;
      n++;
    end
    n = 0;
    bad = 1'b0;
    while (dc_brake_en !== 1'b1 && n < 200) begin
      bad = bad | gate_en | (out_freq != 16'h0);
      @(posedge clk);
      #1;
      n++;
    end
    chk("pre-block output", {31'h0, bad}, 32'h0);
    chk("pre-block ticks", 32'(near((n + TC / 2) / TC, 3)), 32'h3);
    chk("dc level", {16'h0, dc_current_ref}, 32'h32);
    n = 0;
    while (dc_brake_en === 1'b1 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("brake cycles", 32'(n), 32'(4 * TC));
    chk("after brake", {30'h0, gate_en, stopped}, 32'h1);
    chk("motor halted", {16'h0, motor_freq}, 32'h0);
    test_done();
  end
endmodule
